// ### design/sim_uart.sv
`timescale 1ns/1ps
`include "sim_uart_defs.svh"
module sim_uart (
    input  wire logic        clk,            // 250 MHz clock
    input  wire logic        srst,           // Synchronous reset, high
    input  wire logic        psel,           // APB select
    input  wire logic        penable,        // APB enable
    input  wire logic        pwrite,         // APB direction
    input  wire logic [7:0]  paddr,          // APB byte address
    input  wire logic [31:0] pwdata,         // APB write data
    output logic      [31:0] prdata,         // APB read data
    output logic             pready,         // APB ready
    output logic             pslverr,        // APB error on unmapped
    input  wire logic        serial_rx_line, // Card to device
    output logic             serial_tx_line, // Device to card
    output logic             tx_int_req,     // Transmit interrupt pulse
    output logic             rx_int_req      // Receive interrupt pulse
);
    ////////////////////////////////////////////////////////////////////////////
    baud_if bif ();
    logic       wr_en, rd_en, hit, rb_read;
    logic [7:0] baud_divisor_r, transmit_buffer_r, receive_buffer_r;
    logic [3:0] shared_prescaler_r;
    logic       stop_bit_count_r, parity_polarity_r, parity_enable_r, bit_order_select_r;
    logic       transmit_enable_r, rx_enable_bit_r, tx_int_source_select_r;
    logic       data_inversion_select_r, error_signal_enable_r, int_pending_flag_r;
    logic       tx_full_r, rx_full_r, ore_r, fer_r, per_r, err_sum;
    logic [31:0] rd_mux;

    // Total frame length including start bit
    function automatic logic [3:0] frame_len(input logic pe, input logic two_stop);
        frame_len = 4'(`FRAME_BASE + {3'b000, pe} + {3'b000, two_stop});
    endfunction

    // Parity error term: even wants zero sum, odd wants one
    function automatic logic par_bad(input logic sum, input logic even);
        par_bad = sum ^ ~even;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Bus decode; accesses complete with no wait state
    assign wr_en   = psel && penable && pwrite;
    assign rd_en   = psel && penable && !pwrite;
    assign hit     = (paddr == `OFF_TX_BUF) || (paddr == `OFF_RX_BUF) || (paddr == `OFF_BAUD_DIV) ||
                     (paddr == `OFF_MODE) || (paddr == `OFF_CTRL0) || (paddr == `OFF_CTRL1) ||
                     (paddr == `OFF_PRESCALE) || (paddr == `OFF_RX_INT);
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !hit;
    assign rb_read = rd_en && (paddr == `OFF_RX_BUF);
    assign err_sum = ore_r || fer_r || per_r;

    // Read multiplexer
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (paddr)
            `OFF_TX_BUF:   rd_mux[7:0] = transmit_buffer_r;
            `OFF_RX_BUF: begin
                rd_mux[7:0]          = receive_buffer_r;
                rd_mux[`RXB_OVERRUN] = ore_r;
                rd_mux[`RXB_FRAMING] = fer_r;
                rd_mux[`RXB_PARITY]  = per_r;
                rd_mux[`RXB_SUM]     = err_sum;
            end
            `OFF_BAUD_DIV: rd_mux[7:0] = baud_divisor_r;
            `OFF_MODE: begin
                rd_mux[`MODE_STOP_CNT] = stop_bit_count_r;
                rd_mux[`MODE_PAR_POL]  = parity_polarity_r;
                rd_mux[`MODE_PAR_EN]   = parity_enable_r;
            end
            `OFF_CTRL0:    rd_mux[`CTRL0_MSB_FST] = bit_order_select_r;
            `OFF_CTRL1: begin
                rd_mux[`CTRL1_TX_EN]   = transmit_enable_r;
                rd_mux[`CTRL1_TX_EMPT] = !tx_full_r;
                rd_mux[`CTRL1_RX_EN]   = rx_enable_bit_r;
                rd_mux[`CTRL1_TX_IRS]  = tx_int_source_select_r;
                rd_mux[`CTRL1_INVERT]  = data_inversion_select_r;
                rd_mux[`CTRL1_ERR_EN]  = error_signal_enable_r;
            end
            `OFF_PRESCALE: rd_mux[3:0] = shared_prescaler_r;
            `OFF_RX_INT:   rd_mux[`RXI_PENDING] = int_pending_flag_r;
            default:       rd_mux = 32'h0000_0000;
        endcase
    end

    // Read data captured in the setup phase so it comes from a flop
    always_ff @(posedge clk) begin
        if (srst) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= rd_mux;
        end
    end

    // Configuration registers
    always_ff @(posedge clk) begin
        if (srst) begin
            baud_divisor_r          <= `RST_BYTE;
            shared_prescaler_r      <= `RST_NIB;
            stop_bit_count_r        <= 1'b0;
            parity_polarity_r       <= 1'b0;
            parity_enable_r         <= 1'b0;
            bit_order_select_r      <= 1'b0;
            transmit_enable_r       <= 1'b0;
            rx_enable_bit_r         <= 1'b0;
            tx_int_source_select_r  <= 1'b0;
            data_inversion_select_r <= 1'b0;
            error_signal_enable_r   <= 1'b0;
        end else if (wr_en) begin
            case (paddr)
                `OFF_BAUD_DIV: baud_divisor_r     <= pwdata[7:0];
                `OFF_PRESCALE: shared_prescaler_r <= pwdata[3:0];
                `OFF_MODE: begin
                    stop_bit_count_r  <= pwdata[`MODE_STOP_CNT];
                    parity_polarity_r <= pwdata[`MODE_PAR_POL];
                    parity_enable_r   <= pwdata[`MODE_PAR_EN];
                end
                `OFF_CTRL0:    bit_order_select_r <= pwdata[`CTRL0_MSB_FST];
                `OFF_CTRL1: begin
                    transmit_enable_r       <= pwdata[`CTRL1_TX_EN];
                    rx_enable_bit_r         <= pwdata[`CTRL1_RX_EN];
                    tx_int_source_select_r  <= pwdata[`CTRL1_TX_IRS];
                    data_inversion_select_r <= pwdata[`CTRL1_INVERT];
                    error_signal_enable_r   <= pwdata[`CTRL1_ERR_EN];
                end
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Baud tick source at 16x the bit rate
    assign bif.prescale = shared_prescaler_r;
    assign bif.divisor  = baud_divisor_r;
    baud_gen u_baud (
        .clk  (clk),
        .srst (srst),
        .bus  (bif.gen)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Transmitter
    logic        tx_busy_r, tx_load, tx_shift, err_drive_r;
    logic [11:0] tx_sh_r;
    logic [3:0]  tx_left_r, tx_cnt_r;
    logic [7:0]  tx_data, tx_ord;
    logic        tx_par;

    assign tx_load  = transmit_enable_r && tx_full_r && !tx_busy_r;
    assign tx_shift = tx_busy_r && bif.tick && (tx_cnt_r == `OVS_LAST);
    assign tx_data  = data_inversion_select_r ? ~transmit_buffer_r : transmit_buffer_r;
    assign tx_ord   = bit_order_select_r ? {<<{tx_data}} : tx_data;
    assign tx_par   = ^tx_ord ^ ~parity_polarity_r;

    // Buffer write sets full; a write in the load cycle wins
    always_ff @(posedge clk) begin
        if (srst) begin
            transmit_buffer_r <= `RST_BYTE;
            tx_full_r         <= 1'b0;
        end else if (wr_en && paddr == `OFF_TX_BUF) begin
            transmit_buffer_r <= pwdata[7:0];
            tx_full_r         <= 1'b1;
        end else if (tx_load) begin
            tx_full_r <= 1'b0;
        end
    end

    // Shift register sends LSB of the frame word first
    always_ff @(posedge clk) begin
        if (srst) begin
            tx_busy_r <= 1'b0;
            tx_sh_r   <= 12'hFFF;
            tx_left_r <= `RST_NIB;
            tx_cnt_r  <= `RST_NIB;
        end else if (tx_load) begin
            tx_busy_r <= 1'b1;
            tx_cnt_r  <= `RST_NIB;
            tx_left_r <= frame_len(parity_enable_r, stop_bit_count_r);
            tx_sh_r   <= parity_enable_r ? {2'b11, tx_par, tx_ord, 1'b0} : {3'b111, tx_ord, 1'b0};
        end else if (tx_busy_r && bif.tick) begin
            tx_cnt_r <= 4'(tx_cnt_r + 4'h1);
            if (tx_shift) begin
                tx_sh_r   <= {1'b1, tx_sh_r[11:1]};
                tx_left_r <= 4'(tx_left_r - 4'h1);
                tx_busy_r <= (tx_left_r != 4'h1);
            end
        end
    end

    // Interrupt either on load or as the first stop bit starts
    always_ff @(posedge clk) begin
        if (srst) begin
            tx_int_req <= 1'b0;
        end else if (tx_int_source_select_r) begin
            tx_int_req <= tx_shift && (tx_left_r == 4'(4'h2 + {3'b000, stop_bit_count_r}));
        end else begin
            tx_int_req <= tx_load;
        end
    end

    // Line idles high; error signal overrides frame data
    always_ff @(posedge clk) begin
        if (srst) begin
            serial_tx_line <= 1'b1;
        end else begin
            serial_tx_line <= !err_drive_r && (!tx_busy_r || tx_sh_r[0]);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Receiver; the pin passes two flops before any logic looks at it
    sim_uart_pkg::rx_state_e rx_state_r;
    logic       rx_meta_r, rx_s;
    logic [3:0] rx_cnt_r, rx_idx_r, rx_last;
    logic [7:0] rx_sh_r;
    logic       rx_par_r, rx_ovr_r, rx_fer_r, rx_sample, rx_done, par_err;
    logic [4:0] err_cnt_r;

    always_ff @(posedge clk) begin
        if (srst) begin
            rx_meta_r <= 1'b1;
            rx_s      <= 1'b1;
        end else begin
            rx_meta_r <= serial_rx_line;
            rx_s      <= rx_meta_r;
        end
    end

    assign rx_last   = 4'(frame_len(parity_enable_r, stop_bit_count_r) - 4'h2);
    assign rx_sample = (rx_state_r == sim_uart_pkg::RX_BITS) && bif.tick && (rx_cnt_r == `OVS_LAST);
    assign rx_done   = rx_sample && (rx_idx_r == rx_last);
    assign par_err   = parity_enable_r && par_bad(rx_par_r, parity_polarity_r);

    // Bit sequencer: sample mid-start, then every 16 ticks
    always_ff @(posedge clk) begin
        if (srst) begin
            rx_state_r <= sim_uart_pkg::RX_IDLE;
            rx_cnt_r   <= `RST_NIB;
            rx_idx_r   <= `RST_NIB;
        end else begin
            case (rx_state_r)
                sim_uart_pkg::RX_IDLE: begin
                    rx_cnt_r <= `RST_NIB;
                    rx_idx_r <= `RST_NIB;
                    if (rx_enable_bit_r && !rx_s) begin
                        rx_state_r <= sim_uart_pkg::RX_START;
                    end
                end
                sim_uart_pkg::RX_START: begin
                    if (bif.tick) begin
                        rx_cnt_r <= 4'(rx_cnt_r + 4'h1);
                        if (rx_cnt_r == `OVS_MID) begin
                            rx_cnt_r   <= `RST_NIB;
                            rx_state_r <= rx_s ? sim_uart_pkg::RX_IDLE : sim_uart_pkg::RX_BITS;
                        end
                    end
                end
                sim_uart_pkg::RX_BITS: begin
                    if (bif.tick) begin
                        rx_cnt_r <= 4'(rx_cnt_r + 4'h1);
                    end
                    if (rx_sample) begin
                        rx_idx_r <= 4'(rx_idx_r + 4'h1);
                    end
                    if (rx_done || !rx_enable_bit_r) begin
                        rx_state_r <= sim_uart_pkg::RX_IDLE;
                    end
                end
                default: rx_state_r <= sim_uart_pkg::RX_IDLE;
            endcase
        end
    end

    // Data, parity, overrun and stop collection per frame
    always_ff @(posedge clk) begin
        if (srst || rx_state_r == sim_uart_pkg::RX_START) begin
            rx_sh_r  <= `RST_BYTE;
            rx_par_r <= 1'b0;
            rx_ovr_r <= 1'b0;
            rx_fer_r <= 1'b0;
        end else if (rx_sample) begin
            if (rx_idx_r <= `DATA_LAST) begin
                rx_sh_r <= bit_order_select_r ? {rx_sh_r[6:0], rx_s} : {rx_s, rx_sh_r[7:1]};
            end
            if (rx_idx_r < 4'(`DATA_LAST + 4'h1 + {3'b000, parity_enable_r})) begin
                rx_par_r <= rx_par_r ^ rx_s;
            end
            if (rx_idx_r == 4'(`DATA_LAST + {3'b000, parity_enable_r}) && rx_full_r && !rb_read) begin
                rx_ovr_r <= 1'b1;
            end
            if (rx_idx_r > 4'(`DATA_LAST + {3'b000, parity_enable_r}) && !rx_s) begin
                rx_fer_r <= 1'b1;
            end
        end
    end

    // Buffer transfer; a completing frame wins over a same-cycle read
    always_ff @(posedge clk) begin
        if (srst) begin
            receive_buffer_r <= `RST_BYTE;
            rx_full_r        <= 1'b0;
            rx_int_req       <= 1'b0;
        end else begin
            rx_int_req <= 1'b0;
            if (rx_done && !rx_ovr_r && rx_s) begin
                receive_buffer_r <= data_inversion_select_r ? ~rx_sh_r : rx_sh_r;
                rx_full_r        <= 1'b1;
                rx_int_req       <= 1'b1;
            end else if (rx_done && !rx_ovr_r) begin
                receive_buffer_r <= data_inversion_select_r ? ~rx_sh_r : rx_sh_r;
                rx_full_r        <= 1'b1;
                rx_int_req       <= 1'b1;
            end else if (rb_read) begin
                rx_full_r <= 1'b0;
            end
        end
    end

    // Error flags; overrun held until receive is disabled
    always_ff @(posedge clk) begin
        if (srst) begin
            ore_r <= 1'b0;
            fer_r <= 1'b0;
            per_r <= 1'b0;
        end else begin
            if (rx_done && rx_ovr_r) begin
                ore_r <= 1'b1;
            end else if (!rx_enable_bit_r) begin
                ore_r <= 1'b0;
            end
            if (rx_done && !rx_ovr_r) begin
                fer_r <= rx_fer_r || !rx_s;
                per_r <= par_err;
            end else if (rb_read && err_drive_r) begin
                per_r <= 1'b0;
            end
        end
    end

    // Error pulse: starts at the first stop sample, one bit long or until read
    always_ff @(posedge clk) begin
        if (srst) begin
            err_drive_r <= 1'b0;
            err_cnt_r   <= 5'h00;
        end else if (rx_sample && error_signal_enable_r && par_err &&
                     rx_idx_r == 4'(`DATA_LAST + 4'h2)) begin
            err_drive_r <= 1'b1;
            err_cnt_r   <= 5'h00;
        end else if (err_drive_r) begin
            if (rb_read || err_cnt_r == {1'b1, `RST_NIB}) begin
                err_drive_r <= 1'b0;
            end else if (bif.tick) begin
                err_cnt_r <= 5'(err_cnt_r + 5'h01);
            end
        end
    end

    // Receive pending flag; writing zero clears, a new set wins
    always_ff @(posedge clk) begin
        if (srst) begin
            int_pending_flag_r <= 1'b0;
        end else if (rx_int_req) begin
            int_pending_flag_r <= 1'b1;
        end else if (wr_en && paddr == `OFF_RX_INT && !pwdata[`RXI_PENDING]) begin
            int_pending_flag_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    sequence s_rx_begin;
        $past(rx_state_r) == sim_uart_pkg::RX_IDLE ##0 rx_state_r == sim_uart_pkg::RX_START;
    endsequence

    a_tx_start_cond: assert property ($rose(tx_busy_r) |-> $past(transmit_enable_r) && $past(tx_full_r))
        else $error("transmit began without enable and data");
    a_rx_start_cond: assert property (s_rx_begin |-> $past(rx_enable_bit_r) && !$past(rx_s))
        else $error("receive began without enable and start bit");
    a_tx_stop_int: assert property (tx_int_req && tx_int_source_select_r && !err_drive_r |=> serial_tx_line)
        else $error("transmit interrupt not at stop bit");
    a_rx_int_full: assert property (rx_int_req |-> rx_full_r && int_pending_flag_r == $past(int_pending_flag_r) ##1 int_pending_flag_r)
        else $error("receive interrupt without buffer transfer");
    a_ovr_no_int: assert property (rx_done && rx_ovr_r |=> !rx_int_req ##0 ore_r)
        else $error("overrun frame raised receive interrupt");
    a_err_sum: assert property ($rose(ore_r) || $rose(fer_r) || $rose(per_r) |-> err_sum)
        else $error("error sum flag not set");
    a_err_line_low: assert property (err_drive_r |=> !serial_tx_line)
        else $error("error signal not driving line low");
    a_err_release: assert property (rb_read && err_drive_r && !rx_sample |=> !err_drive_r && !per_r ##1 serial_tx_line || tx_busy_r)
        else $error("buffer read did not release error signal");
    a_tx_frame_len: assert property (tx_load |=> tx_left_r == frame_len(parity_enable_r, stop_bit_count_r))
        else $error("transmit frame length wrong");
endmodule // sim_uart

// ### shared/sim_uart_defs.svh
`ifndef SIM_UART_DEFS_SVH
`define SIM_UART_DEFS_SVH

// Register byte offsets
`define OFF_TX_BUF    8'h00
`define OFF_RX_BUF    8'h04
`define OFF_BAUD_DIV  8'h08
`define OFF_MODE      8'h0C
`define OFF_CTRL0     8'h10
`define OFF_CTRL1     8'h14
`define OFF_PRESCALE  8'h18
`define OFF_RX_INT    8'h1C

// Mode register fields
`define MODE_STOP_CNT 4
`define MODE_PAR_POL  5
`define MODE_PAR_EN   6
// Control zero fields
`define CTRL0_MSB_FST 0
// Control one fields
`define CTRL1_TX_EN   0
`define CTRL1_TX_EMPT 1
`define CTRL1_RX_EN   2
`define CTRL1_TX_IRS  4
`define CTRL1_INVERT  5
`define CTRL1_ERR_EN  6
// Receive buffer status fields
`define RXB_OVERRUN   12
`define RXB_FRAMING   13
`define RXB_PARITY    14
`define RXB_SUM       15
// Receive interrupt control fields
`define RXI_PENDING   3

// Reset values and timing
`define RST_BYTE      8'h00
`define RST_NIB       4'h0
`define OVS_LAST      4'hF
`define OVS_MID       4'h7
`define FRAME_BASE    4'hA
`define DATA_LAST     4'h7

`endif

// ### shared/sim_uart_pkg.sv
package sim_uart_pkg;
    // Receiver sequencing
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS} rx_state_e;
endpackage

// ### shared/baud_if.sv
`timescale 1ns/1ps
interface baud_if;
    logic [3:0] prescale;
    logic [7:0] divisor;
    logic       tick;
    modport gen  (input prescale, input divisor, output tick);
    modport user (output prescale, output divisor, input tick);
endinterface

// ### design/baud_gen.sv
`timescale 1ns/1ps
`include "sim_uart_defs.svh"
module baud_gen (
    input wire logic clk,   // 250 MHz clock
    input wire logic srst,  // Synchronous reset
    baud_if.gen      bus    // Divider settings and tick
);
    logic [4:0] pre_cnt_r;
    logic [4:0] pre_lim;
    logic       pre_tick;
    logic [7:0] div_cnt_r;

    // Prescale limit: zero field means no division, else divide by 2n
    assign pre_lim  = (bus.prescale == `RST_NIB) ? 5'h00 : 5'({bus.prescale, 1'b0} - 5'h01);
    assign pre_tick = (pre_cnt_r >= pre_lim);

    // Prescaler stage
    always_ff @(posedge clk) begin
        if (srst || pre_tick) begin
            pre_cnt_r <= 5'h00;
        end else begin
            pre_cnt_r <= 5'(pre_cnt_r + 5'h01);
        end
    end

    // Divisor stage yields the 16x oversampling tick
    always_ff @(posedge clk) begin
        if (srst) begin
            div_cnt_r <= `RST_BYTE;
            bus.tick  <= 1'b0;
        end else begin
            bus.tick <= 1'b0;
            if (pre_tick) begin
                if (div_cnt_r >= bus.divisor) begin
                    div_cnt_r <= `RST_BYTE;
                    bus.tick  <= 1'b1;
                end else begin
                    div_cnt_r <= 8'(div_cnt_r + 8'h01);
                end
            end
        end
    end
endmodule // baud_gen

// ### verif/sim_card_model.sv
`timescale 1ns/1ps
// Card end: sends frames to the device, records frames from it
module sim_card_model (
    input  wire logic clk,      // Bench clock
    input  wire logic from_dev, // Device transmit line
    output logic      to_dev    // Device receive line
);
    logic [9:0] got;
    int         frames = 0;
    initial to_dev = 1'b1;
    // Start, data and parity, stop; 16 clocks a bit at divisor 0
    task automatic send(input logic [8:0] b, input logic stp);
        to_dev <= 1'b0;
        for (int i = 0; i < 11; i++) begin
            repeat (16) @(posedge clk);
            to_dev <= (i < 9) ? b[i] : (i == 9 ? stp : 1'b1);
        end
    endtask
    // Mid-bit sampling; an error pulse also starts a capture, harmless
    always begin
        @(negedge from_dev);
        repeat (8) @(posedge clk);
        for (int i = 0; i < 10; i++) begin
            repeat (16) @(posedge clk);
            got[i] = from_dev;
        end
        frames++;
    end
endmodule // sim_card_model

// ### verif/tb_sim_uart.sv
`timescale 1ns/1ps
`include "sim_uart_defs.svh"
module tb_sim_uart;
    logic        clk, srst, psel, penable, pwrite, rxl, txl, txp, rxp, pready, pslverr, slv_err, rx_at_txi;
    logic [7:0]  paddr, b;
    logic [31:0] pwdata, prdata, q;
    int          mismatches, tests_run, txi, rxi, n, k;
    sim_uart i_dut (.clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .serial_rx_line(rxl), .serial_tx_line(txl), .tx_int_req(txp), .rx_int_req(rxp));
    sim_card_model i_card (.clk(clk), .from_dev(txl), .to_dev(rxl));
    // 250 MHz clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // Interrupt pulse counters; receive line level as a handler would see it
    always @(posedge clk) begin
        txi <= txi + int'(txp === 1'b1);
        rxi <= rxi + int'(rxp === 1'b1);
        if (txp === 1'b1) rx_at_txi <= rxl;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // APB transfer; the idle cycle after keeps each signal set once an edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        q = prdata;
        slv_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    // Software set-up of direct or inverse format
    task automatic cfg(input logic inv, input logic te);
        apb(1, `OFF_MODE, (32'h1 << `MODE_PAR_EN) | ({31'h0, ~inv} << `MODE_PAR_POL));
        apb(1, `OFF_CTRL0, {31'h0, inv});
        apb(1, `OFF_CTRL1, {25'h0, 1'b1, inv, 1'b1, 1'b0, 1'b1, 1'b0, te});
    endtask
    // Line bits in sent order, parity on top
    function automatic logic [8:0] fr(input logic [7:0] d, input logic inv);
        logic [7:0] f;
        for (int i = 0; i < 8; i++) f[i] = inv ? ~d[7 - i] : d[i];
        return {inv ? ~^f : ^f, f};
    endfunction
    // Clocks per bit: 16 ticks, each divisor plus one prescaled clocks
    function automatic int bit_clks(input int div, input int pre);
        return 16 * (div + 1) * (pre == 0 ? 1 : 2 * pre);
    endfunction
    task automatic conclude;
        $display("Checks %0d, mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // Watchdog, well beyond the expected run
    initial begin
        repeat (30000) @(posedge clk);
        mismatches++;
        conclude();
    end
    // Main sequence
    initial begin
        srst = 1'b1;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        void'($urandom(32'hD5A2));
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        for (int inv = 0; inv < 2; inv++) begin
            b = 8'($urandom);
            cfg(inv[0], 1'b0);
            apb(1, `OFF_TX_BUF, {24'h0, b});
            repeat (40) @(posedge clk);
            apb(0, `OFF_CTRL1, 0);
            chk(q[`CTRL1_TX_EMPT], 0);
            chk(txl, 1);
            n = i_card.frames;
            k = txi;
            cfg(inv[0], 1'b1);
            for (int t = 0; t < 400 && i_card.frames == n; t++) @(posedge clk);
            chk(i_card.got, {1'b1, fr(b, inv[0])});
            chk(txi - k, 1);
            chk(rx_at_txi, 1);
            b = 8'($urandom);
            k = rxi;
            i_card.send(fr(b, inv[0]), 1'b1);
            apb(0, `OFF_RX_BUF, 0);
            chk({slv_err, q[15:0]}, {1'b0, 8'h0, b});
            chk(rxi - k, 1);
            apb(0, `OFF_RX_INT, 0);
            chk(q[`RXI_PENDING], 1);
            fork
                i_card.send(fr(b, inv[0]) ^ 9'h100, 1'b1);
                begin
                    for (int t = 0; t < 400 && txl !== 1'b0; t++) @(posedge clk);
                    apb(0, `OFF_RX_BUF, 0);
                    @(posedge clk);
                    chk(q[15:12], 4'hC);
                    chk(txl, 1);
                end
            join
            apb(0, `OFF_RX_BUF, 0);
            chk(q[14], 0);
            repeat (200) @(posedge clk);
            $display("Format %0d done", inv);
        end
        cfg(1'b0, 1'b1);
        k = rxi;
        i_card.send(fr(8'h5A, 0), 1'b1);
        i_card.send(fr(8'hA5, 0), 1'b1);
        apb(0, `OFF_RX_BUF, 0);
        chk({q[15], q[12]}, 2'b11);
        chk(rxi - k, 1);
        apb(1, `OFF_CTRL1, 0);
        i_card.send(fr(8'h3C, 0), 1'b1);
        chk(rxi - k, 1);
        cfg(1'b0, 1'b1);
        i_card.send(fr(8'h3C, 0), 1'b0);
        apb(0, `OFF_RX_BUF, 0);
        chk(q[13], 1);
        $display("Error cases done");
        apb(1, `OFF_BAUD_DIV, 1);
        apb(1, `OFF_PRESCALE, 1);
        apb(1, `OFF_TX_BUF, 1);
        // Time D1 to D7 low run: bit edges follow the tick, the start bit follows the load
        for (int t = 0; t < 400 && txl !== 1'b0; t++) @(posedge clk);
        for (int t = 0; t < 400 && txl !== 1'b1; t++) @(posedge clk);
        for (int t = 0; t < 400 && txl !== 1'b0; t++) @(posedge clk);
        n = 0;
        while (txl === 1'b0 && n < 2000) begin
            @(posedge clk);
            n++;
        end
        chk(n, 7 * bit_clks(1, 1));
        $display("Baud case done");
        conclude();
    end
endmodule // tb_sim_uart
